// File: src/mbpc_pkg.sv
// shared constants for the motor bridge mode and protection controller
package mbpc_pkg;
  // interval figures in microseconds, clock at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int OCP_DEGLITCH_US = 2;
  localparam int RETRY_US = 40;
  localparam int SLEEP_US = 40;
  localparam int WAKE_US = 20;
  localparam int STALL_RELEASE_US = 20;
  localparam int AUTOSLEEP_US = 40;
  localparam int INRUSH_US = 100;
  // cycle counts derived from the figures
  localparam int OCP_CYC = OCP_DEGLITCH_US * CLK_MHZ;
  localparam int RETRY_CYC = RETRY_US * CLK_MHZ;
  localparam int SLEEP_CYC = SLEEP_US * CLK_MHZ;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int STALL_REL_CYC = STALL_RELEASE_US * CLK_MHZ;
  localparam int AUTOSLEEP_CYC = AUTOSLEEP_US * CLK_MHZ;
  localparam int INRUSH_CYC = INRUSH_US * CLK_MHZ;
  localparam int CNT_W = 16;
  // regulation mode select encodings
  localparam logic [1:0] REG_LOW = 2'h0;
  localparam logic [1:0] REG_HIGH = 2'h1;
  localparam logic [1:0] REG_FLOAT = 2'h2;
  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_FAULT = 2'b10
  } mbpc_state_e;
endpackage : mbpc_pkg

// File: src/mbpc_timer.sv
// interval timer: counts while run, done once count reached
`timescale 1ns/1ps
module mbpc_timer (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset
  input wire logic run, // count while high, clear when low
  input wire logic [15:0] limit, // cycles to reach
  output logic done // reached limit
);
  logic [15:0] count;
  assign done = (count >= limit);
  always_ff @(posedge mclk) begin
    if (reset || !run) begin
      count <= 16'h0000;
    end else if (!done) begin
      count <= count + 16'h0001;
    end
  end
endmodule : mbpc_timer

// File: src/mbpc_guard.sv
// fault guard: deglitch qualify then timed retry
`timescale 1ns/1ps
module mbpc_guard (
  input wire logic mclk, // clock
  input wire logic reset, // sync reset
  input wire logic cond, // raw fault condition
  input wire logic [15:0] deglitch, // qualify cycles, 0 for none
  input wire logic [15:0] retry, // retry cycles
  output logic tripped // bridge must stay off
);
  logic qualified;
  logic retry_done;
  logic hold;
  mbpc_timer u_dg (.mclk(mclk), .reset(reset), .run(cond && !hold),
    .limit(deglitch), .done(qualified));
  mbpc_timer u_rt (.mclk(mclk), .reset(reset), .run(hold),
    .limit(retry), .done(retry_done));
  assign tripped = hold;
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold <= 1'b0;
    end else if (!hold && cond && qualified) begin
      hold <= 1'b1;
    end else if (hold && retry_done) begin
      hold <= 1'b0;
    end
  end
endmodule : mbpc_guard

// File: src/mbpc_ctrl.sv
// mode sequencing and protection controller for the h-bridge
`timescale 1ns/1ps
// Summary of operation
// R1: stall release shorter than autosleep interval
// R2: floating mode regulates only during inrush
// R3: qualified overcurrent disables bridge, flags fault
// R4: retry after interval, repeat while overcurrent
// R5: high and low side checked separately
// R6: overcurrent independent of sense path
// R7: overtemperature disables, flags, retries, repeats
// R8: lockout resets logic, disables, flags fault
// R9: split supply uses logic supply lockout
// R10: single supply uses motor supply lockout
// R11: leave lockout only above rising threshold
// R12: active needs supply, input high, wake
// R13: inputs low for interval enters sleep
// R14: host holds input high past wake
// R15: fault mode returns active on recovery
// R16: inrush blanking restarts on listed events
// R17: indication stall release after low interval
// R18: intervals are parameterised cycle counters
// R19: fault flag released on return active
module mbpc_ctrl (
  input wire logic mclk, // 25 MHz clock
  input wire logic reset, // sync reset, active high
  input wire logic drive_input_a, // bridge input a
  input wire logic drive_input_b, // bridge input b
  input wire logic split_supply, // high: split supply operation
  input wire logic logic_supply_fall, // logic supply below falling
  input wire logic logic_supply_rise, // logic supply above rising
  input wire logic motor_supply_fall, // motor supply below falling
  input wire logic motor_supply_rise, // motor supply above rising
  input wire logic [1:0] hs_limit, // high-side fet current limit
  input wire logic [1:0] ls_limit, // low-side fet current limit
  input wire logic over_temp, // die over thermal threshold
  input wire logic [1:0] regulation_mode_sel, // low/high/float
  input wire logic stall_seen, // stall comparator, qualified
  input wire logic stall_response_sel, // high: indication only
  output logic bridge_enable, // bridge fets may drive
  output logic circuits_enable, // internal circuits on
  output logic regulation_enable, // current regulation active
  output logic inrush_blank, // inrush blanking running
  output logic fault_flag_n_o, // fault flag output value
  output logic fault_flag_n_oe, // open drain pulls low
  output logic stall_flag_n_o, // stall flag output value
  output logic stall_flag_n_oe, // open drain pulls low
  output logic [1:0] mode // current mode
);
  mbpc_pkg::mbpc_state_e state, next_state;
  logic any_high, lockout, armed, supply_ok;
  logic ocp_trip, tsd_trip, fault_now;
  logic sleep_done, wake_done, release_done, inrush_done;
  logic stall_latched, blank_run, blank_restart;
  logic [3:0] fet_lim;
  logic [3:0] fet_trip;

  assign any_high = drive_input_a || drive_input_b;
  // supply monitor picked by supply arrangement
  assign lockout = split_supply ? logic_supply_fall //R9
    : motor_supply_fall; //R10
  assign supply_ok = split_supply ? logic_supply_rise
    : motor_supply_rise; //R11

  // per-fet guards, the sense path never feeds them
  assign fet_lim = {hs_limit, ls_limit}; //R6
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_fet
      mbpc_guard u_ocp ( //R5
        .mclk(mclk),
        .reset(reset || lockout),
        .cond(fet_lim[g]),
        .deglitch(16'(mbpc_pkg::OCP_CYC)), //R18
        .retry(16'(mbpc_pkg::RETRY_CYC)),
        .tripped(fet_trip[g])
      );
    end
  endgenerate
  assign ocp_trip = |fet_trip; //R3 R4

  mbpc_guard u_tsd ( //R7
    .mclk(mclk),
    .reset(reset || lockout),
    .cond(over_temp),
    .deglitch(16'h0000),
    .retry(16'(mbpc_pkg::RETRY_CYC)),
    .tripped(tsd_trip)
  );
  assign fault_now = ocp_trip || tsd_trip;

  mbpc_timer u_sleep (.mclk(mclk), .reset(reset || lockout),
    .run(!any_high && state == mbpc_pkg::ST_ACTIVE),
    .limit(16'(mbpc_pkg::SLEEP_CYC)), .done(sleep_done)); //R13
  mbpc_timer u_wake (.mclk(mclk), .reset(reset || lockout),
    .run(any_high && state == mbpc_pkg::ST_SLEEP),
    .limit(16'(mbpc_pkg::WAKE_CYC)), .done(wake_done)); //R14
  // release interval is below autosleep so the flag clears first
  mbpc_timer u_rel (.mclk(mclk), .reset(reset || lockout),
    .run(!any_high && stall_latched && !stall_seen),
    .limit(16'(mbpc_pkg::STALL_REL_CYC)), .done(release_done)); //R1 R17
  mbpc_timer u_inr (.mclk(mclk), .reset(reset || lockout),
    .run(blank_run && !blank_restart),
    .limit(16'(mbpc_pkg::INRUSH_CYC)), .done(inrush_done)); //R16

  // next mode
  always_comb begin
    next_state = state;
    case (state)
      mbpc_pkg::ST_SLEEP: begin
        if (armed && wake_done && any_high) begin
          next_state = mbpc_pkg::ST_ACTIVE; //R12
        end
      end
      mbpc_pkg::ST_ACTIVE: begin
        if (fault_now) begin
          next_state = mbpc_pkg::ST_FAULT; //R15
        end else if (sleep_done && !any_high) begin
          next_state = mbpc_pkg::ST_SLEEP; //R13
        end
      end
      mbpc_pkg::ST_FAULT: begin
        if (!fault_now) begin
          next_state = mbpc_pkg::ST_ACTIVE; //R15
        end
      end
      default: next_state = mbpc_pkg::ST_SLEEP;
    endcase
  end

  // blanking restarts on power-up, fault exit, wake and stall exit
  assign blank_restart = (state != mbpc_pkg::ST_ACTIVE
    && next_state == mbpc_pkg::ST_ACTIVE)
    || (stall_latched && release_done); //R16

  always_ff @(posedge mclk) begin
    if (reset || lockout) begin
      state <= mbpc_pkg::ST_SLEEP; //R8
      armed <= 1'b0;
      blank_run <= 1'b0;
      stall_latched <= 1'b0;
    end else begin
      state <= next_state;
      armed <= armed || supply_ok; //R11
      blank_run <= blank_restart || (blank_run && !inrush_done);
      if (stall_seen && !blank_run && state == mbpc_pkg::ST_ACTIVE) begin
        stall_latched <= 1'b1; // set beats release
      end else if (stall_response_sel && release_done) begin
        stall_latched <= 1'b0; //R17
      end else if (state == mbpc_pkg::ST_SLEEP) begin
        stall_latched <= 1'b0;
      end
    end
  end

  assign inrush_blank = blank_run;
  assign mode = state;
  // latched-disable stall response also stops the bridge
  // lockout cuts the bridge at once, before the mode register follows
  assign bridge_enable = (state == mbpc_pkg::ST_ACTIVE) && !fault_now
    && !lockout //R8
    && !(stall_latched && !stall_response_sel); //R3 R7
  assign circuits_enable = !lockout && state != mbpc_pkg::ST_SLEEP;
  assign regulation_enable = bridge_enable
    && ((regulation_mode_sel == mbpc_pkg::REG_HIGH)
    || (regulation_mode_sel == mbpc_pkg::REG_FLOAT && blank_run)); //R2
  assign fault_flag_n_o = 1'b0;
  // flag low in fault mode, during lockout, released on return
  assign fault_flag_n_oe = lockout || reset
    || state == mbpc_pkg::ST_FAULT; //R8 R19
  assign stall_flag_n_o = 1'b0;
  assign stall_flag_n_oe = stall_latched;

  // checks
  ocp_flag_a: assert property (@(posedge mclk) disable iff (reset) //R3
    (ocp_trip && !lockout) |-> !bridge_enable)
    else $error("bridge on during overcurrent");
  lockout_flag_a: assert property (@(posedge mclk) //R8
    lockout |-> fault_flag_n_oe && !bridge_enable)
    else $error("lockout without fault flag");
  lockout_reset_a: assert property (@(posedge mclk) //R8
    lockout |=> state == mbpc_pkg::ST_SLEEP && !stall_latched)
    else $error("lockout did not reset state");
  float_reg_a: assert property (@(posedge mclk) disable iff (reset) //R2
    (regulation_mode_sel == mbpc_pkg::REG_FLOAT && !blank_run)
    |-> !regulation_enable)
    else $error("float mode regulating after inrush");
  fault_release_a: assert property (@(posedge mclk) //R19
    disable iff (reset || lockout)
    (state == mbpc_pkg::ST_FAULT ##1 state == mbpc_pkg::ST_ACTIVE)
    |-> !fault_flag_n_oe)
    else $error("fault flag held after recovery");
  wake_entry_a: assert property (@(posedge mclk) //R12
    disable iff (reset || lockout)
    ($past(state) == mbpc_pkg::ST_SLEEP
    && state == mbpc_pkg::ST_ACTIVE) |-> $past(any_high) && armed)
    else $error("woke without input high");
  sleep_entry_a: assert property (@(posedge mclk) //R13
    disable iff (reset || lockout)
    ($past(state) == mbpc_pkg::ST_ACTIVE
    && state == mbpc_pkg::ST_SLEEP) |-> $past(!any_high, 1))
    else $error("slept with input high");
  blank_restart_a: assert property (@(posedge mclk) //R16
    disable iff (reset || lockout)
    ($past(state) != mbpc_pkg::ST_ACTIVE
    && state == mbpc_pkg::ST_ACTIVE) |-> blank_run)
    else $error("blanking not restarted");
  fault_enter_a: assert property (@(posedge mclk) //R15
    disable iff (reset || lockout)
    (state == mbpc_pkg::ST_ACTIVE && fault_now)
    |=> state == mbpc_pkg::ST_FAULT)
    else $error("fault mode not entered");

  sleep_bridge_off_a: assert property (@(posedge mclk) //R13
    disable iff (reset || lockout)
    state == mbpc_pkg::ST_SLEEP |-> !bridge_enable && !circuits_enable)
    else $error("bridge or circuits on in sleep");

  tsd_bridge_off_a: assert property (@(posedge mclk) //R7
    disable iff (reset)
    tsd_trip |-> !bridge_enable)
    else $error("bridge on during overtemperature");

  fault_mode_flag_a: assert property (@(posedge mclk) //R15
    disable iff (reset)
    state == mbpc_pkg::ST_FAULT |-> fault_flag_n_oe && !bridge_enable)
    else $error("fault mode without flag");

  fault_flag_free_a: assert property (@(posedge mclk) //R19
    disable iff (reset || lockout)
    state != mbpc_pkg::ST_FAULT |-> !fault_flag_n_oe)
    else $error("fault flag low outside fault");

  stall_disable_a: assert property (@(posedge mclk) //R17
    disable iff (reset || lockout)
    (stall_latched && !stall_response_sel) |-> !bridge_enable)
    else $error("bridge on after latched stall");

  release_short_a: assert property (@(posedge mclk) //R1
    disable iff (reset)
    1'b1 |-> (mbpc_pkg::STALL_REL_CYC < mbpc_pkg::SLEEP_CYC))
    else $error("stall release not below autosleep");

  lockout_disarm_a: assert property (@(posedge mclk) //R11
    disable iff (reset)
    lockout |=> !armed)
    else $error("armed through lockout");

  reg_low_off_a: assert property (@(posedge mclk) //R2
    disable iff (reset)
    regulation_mode_sel == mbpc_pkg::REG_LOW |-> !regulation_enable)
    else $error("regulating in low mode");

  reg_bridge_off_a: assert property (@(posedge mclk) //R2
    disable iff (reset)
    !bridge_enable |-> !regulation_enable)
    else $error("regulating with bridge off");

  ocp_qualify_a: assert property (@(posedge mclk) //R3
    disable iff (reset || lockout)
    $rose(ocp_trip) |-> $past(fet_lim) != 4'h0)
    else $error("overcurrent trip without limit");

  ocp_retry_hold_a: assert property (@(posedge mclk) //R4
    disable iff (reset || lockout)
    $rose(ocp_trip) |=> ocp_trip [*8])
    else $error("overcurrent retry cut short");

  tsd_retry_hold_a: assert property (@(posedge mclk) //R7
    disable iff (reset || lockout)
    $rose(tsd_trip) |=> tsd_trip [*8])
    else $error("thermal retry cut short");

  wake_unarmed_a: assert property (@(posedge mclk) //R12
    disable iff (reset || lockout)
    (state == mbpc_pkg::ST_SLEEP && !armed) |=> state == mbpc_pkg::ST_SLEEP)
    else $error("woke before supply rise");

  stall_blanked_a: assert property (@(posedge mclk) //R16
    disable iff (reset || lockout)
    (blank_run && !stall_latched) |=> !stall_latched)
    else $error("stall latched during blanking");

  active_circuits_a: assert property (@(posedge mclk) //R12
    disable iff (reset || lockout)
    state == mbpc_pkg::ST_ACTIVE |-> circuits_enable)
    else $error("circuits off while active");

  lockout_circuits_a: assert property (@(posedge mclk) //R8
    disable iff (reset)
    lockout |-> !circuits_enable)
    else $error("circuits on during lockout");

  split_lockout_a: assert property (@(posedge mclk) //R9
    disable iff (reset)
    (split_supply && !logic_supply_fall) |-> !lockout)
    else $error("motor supply caused split lockout");

  single_lockout_a: assert property (@(posedge mclk) //R10
    disable iff (reset)
    (!split_supply && motor_supply_fall) |-> lockout)
    else $error("motor supply fall missed");
endmodule : mbpc_ctrl

// File: dv/mbpc_host.sv
// host side model: drives the bridge inputs, resolves open-drain flags
`timescale 1ns/1ps
module mbpc_host (
  input wire logic mclk, // clock
  input wire logic want_a, // requested level on input a
  input wire logic want_b, // requested level on input b
  input wire logic fault_flag_n_oe, // device pulls fault low
  input wire logic stall_flag_n_oe, // device pulls stall low
  output logic drive_input_a, // to device
  output logic drive_input_b, // to device
  output logic fault_flag_n, // wire with pull-up
  output logic stall_flag_n // wire with pull-up
);
  // requests already change off the sampling edge; follow them directly
  // so no same-edge race decides the wake latency
  assign drive_input_a = want_a;
  assign drive_input_b = want_b;
  // pull-up wins whenever the device lets go
  assign fault_flag_n = fault_flag_n_oe ? 1'b0 : 1'b1;
  assign stall_flag_n = stall_flag_n_oe ? 1'b0 : 1'b1;
endmodule : mbpc_host

// File: dv/tb_mbpc_ctrl.sv
// self-checking bench for the bridge mode and protection controller
`timescale 1ns/1ps
module tb_mbpc_ctrl;
  typedef struct {
    logic [1:0] hs;
    logic [1:0] ls;
    logic ot;
    int hold;
    logic trip;
  } mbpc_row_s;
  logic mclk, reset, want_a, want_b, split_supply, over_temp;
  logic logic_supply_fall, logic_supply_rise, stall_seen, stall_response_sel;
  logic motor_supply_fall, motor_supply_rise;
  logic [1:0] hs_limit, ls_limit, regulation_mode_sel, mode;
  logic drive_input_a, drive_input_b, fault_flag_n, stall_flag_n;
  logic bridge_enable, circuits_enable, regulation_enable, inrush_blank;
  logic fault_flag_n_o, fault_flag_n_oe, stall_flag_n_o, stall_flag_n_oe;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  // a glitch shorter than the deglitch must not trip; last row persists
  mbpc_row_s rows [7] = '{'{2'h1, 2'h0, 1'b0, 60, 1'b1},
    '{2'h2, 2'h0, 1'b0, 60, 1'b1}, '{2'h0, 2'h1, 1'b0, 60, 1'b1},
    '{2'h0, 2'h2, 1'b0, 60, 1'b1}, '{2'h0, 2'h0, 1'b1, 3, 1'b1},
    '{2'h1, 2'h0, 1'b0, 20, 1'b0}, '{2'h0, 2'h0, 1'b1, 1200, 1'b1}};
  mbpc_ctrl i_dut (.mclk(mclk), .reset(reset),
    .drive_input_a(drive_input_a), .drive_input_b(drive_input_b),
    .split_supply(split_supply), .logic_supply_fall(logic_supply_fall),
    .logic_supply_rise(logic_supply_rise),
    .motor_supply_fall(motor_supply_fall),
    .motor_supply_rise(motor_supply_rise), .hs_limit(hs_limit),
    .ls_limit(ls_limit), .over_temp(over_temp),
    .regulation_mode_sel(regulation_mode_sel), .stall_seen(stall_seen),
    .stall_response_sel(stall_response_sel), .bridge_enable(bridge_enable),
    .circuits_enable(circuits_enable),
    .regulation_enable(regulation_enable), .inrush_blank(inrush_blank),
    .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe),
    .stall_flag_n_o(stall_flag_n_o), .stall_flag_n_oe(stall_flag_n_oe),
    .mode(mode));
  mbpc_host i_host (.mclk(mclk), .want_a(want_a), .want_b(want_b),
    .fault_flag_n_oe(fault_flag_n_oe), .stall_flag_n_oe(stall_flag_n_oe),
    .drive_input_a(drive_input_a), .drive_input_b(drive_input_b),
    .fault_flag_n(fault_flag_n), .stall_flag_n(stall_flag_n));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // bounded wait for a mode, then the mode itself is compared
  task automatic wait_mode(input logic [1:0] m, input int lim);
    int n;
    n = 0;
    while (mode !== m && n < lim) begin
      @(negedge mclk);
      n++;
    end
    check(mode, m);
  endtask : wait_mode
  task automatic close_out;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out
  // whole run is near 19000 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    reset = 1'b1; want_a = 1'b0; want_b = 1'b0; split_supply = 1'b0;
    logic_supply_fall = 1'b0; logic_supply_rise = 1'b1; over_temp = 1'b0;
    motor_supply_fall = 1'b0; motor_supply_rise = 1'b1; hs_limit = 2'h0;
    ls_limit = 2'h0; regulation_mode_sel = mbpc_pkg::REG_LOW;
    stall_seen = 1'b0; stall_response_sel = 1'b1;
    cyc(20);
    check(mode, 2'(mbpc_pkg::ST_SLEEP));
    check(fault_flag_n, 1'b0);
    reset = 1'b0;
    want_a = 1'b1;
    wait_mode(2'(mbpc_pkg::ST_ACTIVE), 600);
    cyc(1);
    check({bridge_enable, fault_flag_n}, 2'h3);
    check(inrush_blank, 1'b1);
    foreach (rows[i]) begin
      hs_limit = rows[i].hs; ls_limit = rows[i].ls; over_temp = rows[i].ot;
      cyc(rows[i].hold);
      check(bridge_enable, !rows[i].trip);
      check(fault_flag_n, !rows[i].trip);
      if (rows[i].trip) check(mode, 2'(mbpc_pkg::ST_FAULT));
      hs_limit = 2'h0; ls_limit = 2'h0; over_temp = 1'b0;
      wait_mode(2'(mbpc_pkg::ST_ACTIVE), 1200);
      cyc(1);
      check(fault_flag_n, 1'b1);
    end
    check(inrush_blank, 1'b1);
    regulation_mode_sel = mbpc_pkg::REG_FLOAT;
    cyc(1);
    check(regulation_enable, 1'b1);
    regulation_mode_sel = mbpc_pkg::REG_HIGH;
    cyc(1);
    check(regulation_enable, 1'b1);
    regulation_mode_sel = mbpc_pkg::REG_FLOAT;
    cyc(mbpc_pkg::INRUSH_CYC + 100);
    check({inrush_blank, regulation_enable}, 2'h0);
    regulation_mode_sel = mbpc_pkg::REG_LOW;
    want_a = 1'b0;
    cyc(mbpc_pkg::SLEEP_CYC - 20);
    check(mode, 2'(mbpc_pkg::ST_ACTIVE));
    cyc(40);
    check({mode, bridge_enable}, {2'(mbpc_pkg::ST_SLEEP), 1'b0});
    want_b = 1'b1;
    cyc(mbpc_pkg::WAKE_CYC - 100);
    check(mode, 2'(mbpc_pkg::ST_SLEEP));
    wait_mode(2'(mbpc_pkg::ST_ACTIVE), 200);
    split_supply = 1'b1;
    motor_supply_fall = 1'b1;
    cyc(5);
    check(mode, 2'(mbpc_pkg::ST_ACTIVE));
    logic_supply_fall = 1'b1;
    logic_supply_rise = 1'b0;
    cyc(3);
    check({mode, bridge_enable}, {2'(mbpc_pkg::ST_SLEEP), 1'b0});
    check(fault_flag_n, 1'b0);
    logic_supply_fall = 1'b0;
    cyc(mbpc_pkg::WAKE_CYC + 50);
    check(mode, 2'(mbpc_pkg::ST_SLEEP));
    logic_supply_rise = 1'b1;
    wait_mode(2'(mbpc_pkg::ST_ACTIVE), 700);
    check(circuits_enable, 1'b1);
    cyc(mbpc_pkg::INRUSH_CYC + 10);
    stall_seen = 1'b1;
    cyc(2);
    check({stall_flag_n, bridge_enable}, 2'h1);
    stall_seen = 1'b0;
    want_b = 1'b0;
    cyc(mbpc_pkg::STALL_REL_CYC + 10);
    check({stall_flag_n, mode}, {1'b1, 2'(mbpc_pkg::ST_ACTIVE)});
    want_b = 1'b1;
    cyc(mbpc_pkg::INRUSH_CYC + 10);
    stall_response_sel = 1'b0;
    stall_seen = 1'b1;
    cyc(2);
    check({stall_flag_n, bridge_enable}, 2'h0);
    stall_seen = 1'b0;
    want_b = 1'b0;
    cyc(mbpc_pkg::SLEEP_CYC + 10);
    check({mode, stall_flag_n, circuits_enable},
      {2'(mbpc_pkg::ST_SLEEP), 1'b1, 1'b0});
    close_out;
  end
endmodule : tb_mbpc_ctrl
